// ===== rtl/clm_pkg.sv
// Package: constants and types of the component lifetime monitor
package clm_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 10_000_000;
   localparam int SEC_S           = 1;
   localparam int SEC_CYCLES_DEF  = SEC_S * CLK_HZ;
   localparam int TICK_US         = 10;
   localparam int TICK_CYCLES     = TICK_US * (CLK_HZ / 1_000_000);
   localparam logic [15:0] HOUR_S = 16'h0E10;   // 3600 s

   // ------------------------------------------------------------
   // Judgment levels and special codes
   // ------------------------------------------------------------
   localparam logic [7:0]  BUS_PCT_TH   = 8'h55;    // 85 %
   localparam logic [7:0]  PCT_FULL     = 8'h64;    // 100 %
   localparam logic [7:0]  PCT_MAX      = 8'hFF;
   localparam logic [15:0] BRD_HOURS_TH = 16'hEE48; // 61000 h
   localparam logic [15:0] FAN_TH_SMALL = 16'h9C40; // 40000 h
   localparam logic [15:0] FAN_TH_LARGE = 16'h55F0; // 22000 h
   localparam logic [15:0] CNT_MAX      = 16'hFFFF;
   localparam logic [15:0] CODE_ARM     = 16'h0000;
   localparam logic [15:0] CODE_FAIL    = 16'h0001;
   localparam logic [15:0] CODE_RESTORE = 16'h0002;

   // Ambient weighting of board capacitor time
   localparam logic [7:0]  TEMP_REF     = 8'h28;    // 40 C
   localparam logic [7:0]  TEMP_HOT     = 8'h32;    // 50 C
   localparam logic [15:0] WEIGHT_COOL  = 16'h0001;
   localparam logic [15:0] WEIGHT_WARM  = 16'h0002;
   localparam logic [15:0] WEIGHT_HOT   = 16'h0004;
   localparam logic [7:0]  COND_TEMP_TOL = 8'h05;

   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_MAINT = 8'h00;
   localparam logic [7:0] ADDR_MEAS  = 8'h04;
   localparam logic [7:0] ADDR_INIT  = 8'h08;
   localparam logic [7:0] ADDR_STAT  = 8'h0C;
   localparam logic [7:0] ADDR_BRD   = 8'h10;
   localparam logic [7:0] ADDR_FAN   = 8'h14;
   localparam int MAINT_CRIT_BIT  = 3;
   localparam int MAINT_SEL_LSB   = 4;
   localparam int MAINT_NEG_BIT   = 8;
   localparam int MAINT_LARGE_BIT = 9;
   localparam int STAT_PCT_LSB    = 8;
   localparam logic MAINT_CRIT_RST = 1'b0;
   localparam logic [2:0] SEL_RELAY_GEN = 3'h4;
   localparam logic [2:0] SEL_RELAY_ALM = 3'h5;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       main_power_on;
      logic       bus_discharged;
      logic       cap_voltage_on;
      logic       fan_running;
      logic       drive_running;
      logic [7:0] ambient_temp;
   } clm_pins_t;

   typedef struct packed {
      logic [3:0] transistor_out;
      logic       relay_output_general;
      logic       relay_output_alarm;
      logic       lifetime_alarm;
      logic       measuring_ind;
   } clm_outs_t;

   typedef enum logic [0:0] {CLM_IDLE, CLM_DISCH} clm_mstate_t;

endpackage : clm_pkg

// ===== rtl/clm_monitor.sv
// Component lifetime monitor with APB register access
//
// Summary of operation
// - Report bus capacitance as percent of reference
// - Bus alarm when percent at or below 85
// - Board capacitor hours weighted by ambient temperature
// - Board and fan time counted in hours
// - Board alarm at 61000 hours or more
// - Fan hours count only while fan runs
// - Fan alarm 40000 small, 22000 large drives
// - Any alarm drives selected output terminal
// - Maintenance bit 3 selects user conditions
// - Selection bit resets to factory conditions
// - Both codes zero while stopped arms capture
// - Capture stores measurement conditions automatically
// - Show in-progress indication while measuring
// - Successful capture reads back 100 percent with maintenance bit 3 set
// - Failed capture writes 0001 to both codes
// - Writing 0002 restores factory reference
// - Measure every switch-off when conditions met
// - Negative logic: outputs on while not running
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module clm_monitor
   import clm_pkg::*;
#(
   parameter logic [23:0] SEC_CYCLES  = 24'(SEC_CYCLES_DEF),
   parameter logic [15:0] FACTORY_REF = 16'h1000,
   parameter logic [7:0]  FACTORY_TEMP = 8'h19
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire clm_pins_t   pins,
   output clm_outs_t        outs
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      clm_pins_t   s1;
      clm_pins_t   s2;
      logic        pwr_prev;
      logic [23:0] sec_cnt;
      logic [15:0] brd_sec;
      logic [15:0] brd_hours;
      logic [15:0] fan_sec;
      logic [15:0] fan_hours;
      logic        crit_user;
      logic [2:0]  out_sel;
      logic        neg_logic;
      logic        fan_large;
      logic [15:0] meas_code;
      logic [15:0] init_code;
      logic        armed;
      logic        user_valid;
      logic        cond_fan;
      logic [7:0]  cond_temp;
      clm_mstate_t mst;
      logic        capture;
      logic        pend_fan;
      logic [7:0]  pend_temp;
      logic [7:0]  tick;
      logic [15:0] dis_cnt;
      logic [22:0] rem;
      logic [7:0]  quo;
      logic [7:0]  pct;
      logic        div_ok, pct_rdy;
      logic        bus_alarm;
      logic        brd_alarm;
      logic        fan_alarm;
      clm_outs_t   outs;
      logic [31:0] prdata;
   } clm_state_t;

   function automatic clm_state_t rst_state();
      clm_state_t r;
      r = '0;
      r.crit_user = MAINT_CRIT_RST;
      r.init_code = FACTORY_REF;
      r.meas_code = FACTORY_REF;
      r.cond_fan  = 1'b1;
      r.cond_temp = FACTORY_TEMP;
      return r;
   endfunction : rst_state

   localparam clm_state_t RST_S = rst_state();

   clm_state_t q;
   clm_state_t d;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic addr_ok(input logic [7:0] a);
      return (a == ADDR_MAINT) || (a == ADDR_MEAS) || (a == ADDR_INIT) ||
             (a == ADDR_STAT)  || (a == ADDR_BRD)  || (a == ADDR_FAN);
   endfunction : addr_ok

   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == CNT_MAX) ? v : v + 16'h0001;
   endfunction : sat_inc

   function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                           input logic [7:0] b);
      return (a > b) ? a - b : b - a;
   endfunction : abs_diff

   // Hotter air ages the electrolyte faster
   function automatic logic [15:0] temp_weight(input logic [7:0] t);
      if (t > TEMP_HOT)
         return WEIGHT_HOT;
      else if (t > TEMP_REF)
         return WEIGHT_WARM;
      else
         return WEIGHT_COOL;
   endfunction : temp_weight

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic        use_user;
   logic        ref_fan;
   logic [7:0]  ref_temp;
   logic [15:0] ref_val;
   logic        pct_valid;
   logic        cond_ok;
   logic        pwr_fall;
   logic        sec_tick;
   logic        wr;
   logic        any_alarm;
   logic        out_on;
   logic [31:0] rd;

   always_comb
   begin
      d = q;
      d.s1 = pins;
      d.s2 = q.s1;
      d.pwr_prev = q.s2.main_power_on;

      use_user  = q.crit_user && q.user_valid;
      ref_fan   = use_user ? q.cond_fan : 1'b1;
      ref_temp  = use_user ? q.cond_temp : FACTORY_TEMP;
      ref_val   = use_user ? q.init_code : FACTORY_REF;
      pct_valid = (ref_val > CODE_RESTORE) && (q.meas_code > CODE_RESTORE);
      cond_ok   = (q.s2.fan_running == ref_fan) &&
                  (abs_diff(q.s2.ambient_temp, ref_temp) <= COND_TEMP_TOL);
      pwr_fall  = q.pwr_prev && !q.s2.main_power_on;

      // Hour base
      sec_tick = (q.sec_cnt == SEC_CYCLES - 24'h000001);
      d.sec_cnt = sec_tick ? '0 : q.sec_cnt + 24'h000001;
      if (sec_tick && q.s2.cap_voltage_on)
      begin
         d.brd_sec = q.brd_sec + temp_weight(q.s2.ambient_temp);
         if (d.brd_sec >= HOUR_S)
         begin
            d.brd_sec   = d.brd_sec - HOUR_S;
            d.brd_hours = sat_inc(q.brd_hours);
         end
      end
      if (sec_tick && q.s2.fan_running)
      begin
         d.fan_sec = q.fan_sec + WEIGHT_COOL;
         if (d.fan_sec >= HOUR_S)
         begin
            d.fan_sec   = '0;
            d.fan_hours = sat_inc(q.fan_hours);
         end
      end

      // Percent by subtraction; validity rides with the loaded operands
      if ((q.rem >= {7'h00, ref_val}) && (q.quo != PCT_MAX) && q.div_ok)
      begin
         d.rem = q.rem - {7'h00, ref_val};
         d.quo = q.quo + 8'h01;
      end
      else
      begin
         d.pct     = q.div_ok ? q.quo : 8'h00;
         d.pct_rdy = q.div_ok;
         d.div_ok  = pct_valid;
         d.rem = 23'(q.meas_code) * 23'(PCT_FULL);
         d.quo = '0;
      end

      // Discharge measurement at switch-off
      case (q.mst)
         CLM_IDLE:
         begin
            if (pwr_fall && !q.s2.drive_running)
            begin
               if (q.armed || (cond_ok && ref_val > CODE_RESTORE))
               begin
                  d.mst       = CLM_DISCH;
                  d.capture   = q.armed;
                  d.pend_fan  = q.s2.fan_running;
                  d.pend_temp = q.s2.ambient_temp;
                  d.tick      = '0;
                  d.dis_cnt   = '0;
               end
            end
         end
         CLM_DISCH:
         begin
            if (q.tick == 8'(TICK_CYCLES - 1))
            begin
               d.tick    = '0;
               d.dis_cnt = sat_inc(q.dis_cnt);
            end
            else
               d.tick = q.tick + 8'h01;
            if (q.s2.bus_discharged)
            begin
               d.mst = CLM_IDLE;
               if (q.capture && q.dis_cnt > CODE_RESTORE)
               begin
                  d.init_code  = q.dis_cnt;
                  d.meas_code  = q.dis_cnt;
                  d.cond_fan   = q.pend_fan;
                  d.cond_temp  = q.pend_temp;
                  d.user_valid = 1'b1;
               end
               else if (q.capture)
               begin
                  d.init_code = CODE_FAIL;
                  d.meas_code = CODE_FAIL;
               end
               else if (q.dis_cnt > CODE_RESTORE)
                  d.meas_code = q.dis_cnt;
            end
            else if (q.s2.main_power_on || q.dis_cnt == CNT_MAX)
            begin
               // Power came back or bus never drained: no valid time
               d.mst = CLM_IDLE;
               if (q.capture)
               begin
                  d.init_code = CODE_FAIL;
                  d.meas_code = CODE_FAIL;
               end
            end
         end
         default:
            d.mst = CLM_IDLE;
      endcase

      // Register writes take effect at the access edge
      wr = psel && penable && pwrite && addr_ok(paddr);
      if (wr && paddr == ADDR_MAINT)
      begin
         d.crit_user = pwdata[MAINT_CRIT_BIT];
         d.out_sel   = pwdata[MAINT_SEL_LSB +: 3];
         d.neg_logic = pwdata[MAINT_NEG_BIT];
         d.fan_large = pwdata[MAINT_LARGE_BIT];
      end
      if (wr && paddr == ADDR_MEAS)
         d.meas_code = pwdata[15:0];
      if (wr && paddr == ADDR_INIT)
      begin
         if (pwdata[15:0] == CODE_RESTORE)
         begin
            d.init_code  = FACTORY_REF;
            d.cond_fan   = 1'b1;
            d.cond_temp  = FACTORY_TEMP;
            d.user_valid = 1'b0;
         end
         else
            d.init_code = pwdata[15:0];
      end
      // Armed while both codes hold zero, set only when stopped
      d.armed = (d.meas_code == CODE_ARM) && (d.init_code == CODE_ARM) &&
                (q.armed || !q.s2.drive_running);

      // Judgment levels
      d.bus_alarm = pct_valid && q.pct_rdy && (q.pct <= BUS_PCT_TH);
      d.brd_alarm = q.brd_hours >= BRD_HOURS_TH;
      d.fan_alarm = q.fan_hours >=
                    (q.fan_large ? FAN_TH_LARGE : FAN_TH_SMALL);

      // Terminal outputs
      any_alarm = q.bus_alarm || q.brd_alarm || q.fan_alarm;
      out_on = q.neg_logic ? (!q.s2.drive_running || !any_alarm)
                           : any_alarm;
      for (int i = 0; i < 4; i++)
         d.outs.transistor_out[i] = out_on && (q.out_sel == 3'(i));
      d.outs.relay_output_general = out_on && (q.out_sel == SEL_RELAY_GEN);
      d.outs.relay_output_alarm   = out_on && (q.out_sel == SEL_RELAY_ALM);
      d.outs.lifetime_alarm       = any_alarm;
      d.outs.measuring_ind        = (q.mst == CLM_DISCH);

      // Read data captured in the setup cycle
      rd = '0;
      case (paddr)
         ADDR_MAINT:
         begin
            rd[MAINT_CRIT_BIT]      = q.crit_user;
            rd[MAINT_SEL_LSB +: 3]  = q.out_sel;
            rd[MAINT_NEG_BIT]       = q.neg_logic;
            rd[MAINT_LARGE_BIT]     = q.fan_large;
         end
         ADDR_MEAS: rd[15:0] = q.meas_code;
         ADDR_INIT: rd[15:0] = q.init_code;
         ADDR_STAT:
         begin
            rd[0] = q.bus_alarm;
            rd[1] = q.brd_alarm;
            rd[2] = q.fan_alarm;
            rd[3] = (q.mst == CLM_DISCH);
            rd[4] = q.armed;
            rd[5] = q.user_valid;
            rd[STAT_PCT_LSB +: 8] = q.pct;
         end
         ADDR_BRD:  rd[15:0] = q.brd_hours;
         ADDR_FAN:  rd[15:0] = q.fan_hours;
         default:   rd = '0;
      endcase
      if (psel && !penable)
         d.prdata = rd;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= RST_S;
      else
         q <= d;
   end

   assign prdata  = q.prdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok(paddr);
   assign outs    = q.outs;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic cap_ok_ev, cap_fail_ev;
   assign cap_ok_ev   = q.mst == CLM_DISCH && q.capture &&
                        q.s2.bus_discharged && q.dis_cnt > CODE_RESTORE;
   assign cap_fail_ev = q.mst == CLM_DISCH && q.capture &&
                        !q.s2.bus_discharged && q.s2.main_power_on;

   full_scale_a: assert property (cap_ok_ev && q.crit_user ##1
         (q.crit_user && !wr) [*2] |-> ##[1:600] q.pct == PCT_FULL)
      else $error("capture did not read back full scale");
   bus_alarm_a: assert property (pct_valid && q.pct_rdy &&
         q.pct <= BUS_PCT_TH |=> ##1 outs.lifetime_alarm)
      else $error("bus capacitor alarm missing");
   brd_alarm_a: assert property (q.brd_hours >= BRD_HOURS_TH |=>
         q.brd_alarm ##1 outs.lifetime_alarm)
      else $error("board capacitor alarm missing");
   fan_count_a: assert property (q.fan_hours != $past(q.fan_hours) |->
         $past(q.s2.fan_running, 1))
      else $error("fan hours grew while fan stopped");
   fan_level_a: assert property (q.fan_large &&
         q.fan_hours >= FAN_TH_LARGE |=> q.fan_alarm)
      else $error("large drive fan alarm missing");
   alarm_out_a: assert property (q.brd_alarm && !q.neg_logic &&
         q.out_sel == 3'h0 |=> outs.transistor_out[0])
      else $error("alarm not on selected output");
   fail_code_a: assert property (cap_fail_ev && !wr |=>
         q.meas_code == CODE_FAIL && q.init_code == CODE_FAIL)
      else $error("failure code not written");
   restore_a: assert property (wr && paddr == ADDR_INIT &&
         pwdata[15:0] == CODE_RESTORE |=>
         q.init_code == FACTORY_REF && !q.user_valid)
      else $error("factory reference not restored");
   meas_ind_a: assert property (q.mst == CLM_DISCH |=>
         outs.measuring_ind)
      else $error("in-progress indication missing");
   neg_logic_a: assert property (q.neg_logic && !q.s2.drive_running &&
         q.out_sel == SEL_RELAY_GEN |=> outs.relay_output_general)
      else $error("negative logic output not on");
   hour_sat_a: assert property (q.brd_hours == CNT_MAX |=>
         q.brd_hours == CNT_MAX)
      else $error("board hours wrapped");

   cap_ok_c:   cover property (cap_ok_ev);
   cap_fail_c: cover property (cap_fail_ev);
   alarm_c:    cover property (outs.lifetime_alarm);
   restore_c:  cover property (wr && paddr == ADDR_INIT &&
                               pwdata[15:0] == CODE_RESTORE);

endmodule : clm_monitor
`default_nettype wire

// ===== dv/clm_drive_model.sv
// Drive-side model: mains, bus decay, fan, run state and ambient
`timescale 1ns/1ps
`default_nettype none
module clm_drive_model
   import clm_pkg::*;
(
   input  wire logic pclk,
   output clm_pins_t pins
);
   // ------------------------------------------------------------
   // Plant state, mains on, drive stopped, fan off, 60 C
   // ------------------------------------------------------------
   initial
   begin
      pins = {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h3C};
   end

   task automatic set_env(input logic fan,
                          input logic run,
                          input logic [7:0] temp);
      @(posedge pclk);
      pins.fan_running   <= fan;
      pins.drive_running <= run;
      pins.ambient_temp  <= temp;
   endtask : set_env

   // Mains drop; bus stays charged until discharge is called
   task automatic switch_off;
      @(posedge pclk);
      pins.main_power_on <= 1'b0;
   endtask : switch_off

   task automatic discharge;
      @(posedge pclk);
      pins.bus_discharged <= 1'b1;
   endtask : discharge

   task automatic switch_on;
      @(posedge pclk);
      pins.main_power_on  <= 1'b1;
      pins.bus_discharged <= 1'b0;
   endtask : switch_on
endmodule : clm_drive_model
`default_nettype wire

// ===== dv/clm_monitor_tb.sv
// Self-checking bench for the component lifetime monitor
`timescale 1ns/1ps
`default_nettype none
module clm_monitor_tb
   import clm_pkg::*;
;
   localparam logic [15:0] REF = 16'h0064;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        pready;
   logic        pslverr;
   logic        err;
   clm_pins_t   pins;
   clm_outs_t   outs;
   int          errors   = 0;
   int          compares = 0;
   int          cyc      = 0;

   always #50 pclk = ~pclk;
   always @(posedge pclk) cyc <= presetn ? cyc + 1 : 0;

   // Short second keeps an hour at 14400 cycles
   clm_monitor #(.SEC_CYCLES(24'h00_0004), .FACTORY_REF(REF))
   i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
          .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
          .prdata(prdata), .pready(pready), .pslverr(pslverr),
          .pins(pins), .outs(outs));
   clm_drive_model i_drv (.pclk(pclk), .pins(pins));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rdchk

   task automatic results;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rdchk(ADDR_MAINT, 32'h0000_0000);
      rdchk(ADDR_INIT, 32'(REF));
      apb(1'b1, ADDR_MAINT, 32'h0000_0208);
      rdchk(ADDR_MAINT, 32'h0000_0208);
      apb(1'b0, 8'h18, 32'h0000_0000);
      check({rd[29:0], pready, err}, 32'h0000_0003);
   endtask : t_regs

   // Percent at and just above the 85 boundary, then terminal select
   task automatic t_alarm;
      logic [7:0] e;
      apb(1'b1, ADDR_MEAS, 32'h0000_0056);
      repeat (300) @(posedge pclk);
      rdchk(ADDR_STAT, 32'h0000_5600);
      apb(1'b1, ADDR_MEAS, 32'h0000_0055);
      repeat (300) @(posedge pclk);
      rdchk(ADDR_STAT, 32'h0000_5501);
      for (int k = 0; k < 6; k++)
      begin
         apb(1'b1, ADDR_MAINT, 32'(k) << MAINT_SEL_LSB);
         repeat (4) @(posedge pclk);
         e = (k < 4) ? (8'h10 << k) : ((k == 4) ? 8'h08 : 8'h04);
         check(32'(outs), 32'(e | 8'h02));
      end
      apb(1'b1, ADDR_MAINT, 32'h0000_0150);
      i_drv.set_env(1'b0, 1'b1, 8'h3C);
      repeat (6) @(posedge pclk);
      check(32'(outs), 32'h0000_0002);
      i_drv.set_env(1'b0, 1'b0, 8'h3C);
      repeat (6) @(posedge pclk);
      check(32'(outs), 32'h0000_0006);
      apb(1'b1, ADDR_MAINT, 32'h0000_0008);
      apb(1'b1, ADDR_MEAS, 32'(REF));
      repeat (300) @(posedge pclk);
      check(32'(outs), 32'h0000_0000);
   endtask : t_alarm

   // Armed capture, then a normal measurement, then a refused one
   task automatic t_capture;
      logic [31:0] ref_q;
      apb(1'b1, ADDR_MEAS, 32'h0000_0000);
      apb(1'b1, ADDR_INIT, 32'h0000_0000);
      apb(1'b0, ADDR_STAT, 32'h0000_0000);
      check(32'(rd[4]), 32'h0000_0001);
      i_drv.switch_off();
      repeat (10) @(posedge pclk);
      check(32'(outs.measuring_ind), 32'h0000_0001);
      repeat (990) @(posedge pclk);
      i_drv.discharge();
      repeat (20) @(posedge pclk);
      check(32'(outs.measuring_ind), 32'h0000_0000);
      apb(1'b0, ADDR_INIT, 32'h0000_0000);
      ref_q = rd;
      check(32'(ref_q inside {[16'h0008:16'h000B]}), 32'h0000_0001);
      rdchk(ADDR_MEAS, ref_q);
      i_drv.switch_on();
      repeat (300) @(posedge pclk);
      rdchk(ADDR_STAT, 32'h0000_6420);
      i_drv.switch_off();
      repeat (10) @(posedge pclk);
      check(32'(outs.measuring_ind), 32'h0000_0001);
      repeat (590) @(posedge pclk);
      i_drv.discharge();
      repeat (20) @(posedge pclk);
      apb(1'b0, ADDR_MEAS, 32'h0000_0000);
      check(32'(rd inside {[16'h0004:16'h0007]}), 32'h0000_0001);
      rdchk(ADDR_INIT, ref_q);
      i_drv.switch_on();
      i_drv.set_env(1'b0, 1'b1, 8'h3C);
      i_drv.switch_off();
      repeat (10) @(posedge pclk);
      check(32'(outs.measuring_ind), 32'h0000_0000);
      i_drv.switch_on();
      i_drv.set_env(1'b0, 1'b0, 8'h3C);
   endtask : t_capture

   // Mains return mid-capture, then factory restore
   task automatic t_fail;
      apb(1'b1, ADDR_MEAS, 32'h0000_0000);
      apb(1'b1, ADDR_INIT, 32'h0000_0000);
      i_drv.switch_off();
      repeat (500) @(posedge pclk);
      i_drv.switch_on();
      repeat (20) @(posedge pclk);
      rdchk(ADDR_MEAS, 32'h0000_0001);
      rdchk(ADDR_INIT, 32'h0000_0001);
      apb(1'b1, ADDR_INIT, 32'h0000_0002);
      rdchk(ADDR_INIT, 32'(REF));
   endtask : t_fail

   // One hour after release: fan hours and weighted board hours
   task automatic t_hours(input logic [31:0] fan, input logic [31:0] brd);
      while (cyc < 14500) @(posedge pclk);
      rdchk(ADDR_FAN, fan);
      rdchk(ADDR_BRD, brd);
   endtask : t_hours

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_alarm();
      t_capture();
      t_fail();
      t_hours(32'h0000_0000, 32'h0000_0004);
      presetn <= 1'b0;
      i_drv.set_env(1'b1, 1'b0, 8'h2D);
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      t_hours(32'h0000_0001, 32'h0000_0002);
      results();
   end

   initial
   begin
      repeat (60000) @(posedge pclk);
      errors++;
      results();
   end
endmodule : clm_monitor_tb
`default_nettype wire
